// File: verification/scs_peer.sv
// far-end peer model: answers each service-check frame after a short or long delay
`timescale 1ns/1ps
module scs_peer (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// link events
	input wire logic schk_send,
	output logic schk_rx,
	// behaviour control
	input wire logic answer_en,
	input wire logic slow
);
	logic [5:0] cnt_r;
	logic busy_r;
	// slow answer still lands well inside the shortest interval
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_r <= 6'h00;
			busy_r <= 1'b0;
			schk_rx <= 1'b0;
		end else begin
			schk_rx <= 1'b0;
			if (schk_send && answer_en) begin
				busy_r <= 1'b1;
				cnt_r <= slow ? 6'h28 : 6'h02;
			end else if (busy_r) begin
				cnt_r <= cnt_r - 6'h01;
				if (cnt_r == 6'h00) begin
					busy_r <= 1'b0;
					schk_rx <= 1'b1;
				end
			end
		end
	end
endmodule // scs_peer

// File: verification/scs_supervisor_bench.sv
// self-checking bench for the supervisor
`timescale 1ns/1ps
module scs_supervisor_bench;
	import scs_pkg::*;
	typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] e;} scs_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, schk_send, schk_rx;
	logic ratio_byte_en, test_active, relay_on, irq, peer_on, peer_slow;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] src_live;
	logic [3:0] src_activity = 4'h0;
	logic [SCS_ALM_W-1:0] alarm_in;
	scs_src_t clk_sel;
	scs_row_t rows [14];
	int error_cnt, samples_checked, n;
	int cycle_cnt = 0;
	scs_supervisor #(.TICK_CYC(20), .ACT_WIN_CYC(16)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .schk_send(schk_send),
		.schk_rx(schk_rx), .ratio_byte_en(ratio_byte_en), .test_active(test_active),
		.src_activity(src_activity), .clk_sel(clk_sel), .alarm_in(alarm_in),
		.relay_on(relay_on), .irq(irq));
	scs_peer peer (.pclk(pclk), .presetn(presetn), .schk_send(schk_send), .schk_rx(schk_rx),
		.answer_en(peer_on), .slow(peer_slow));
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// live sources toggle every cycle, dead ones freeze
	always @(posedge pclk) src_activity <= src_activity ^ src_live;
	////////////////////////////////////////////////////////////////////////////////
	task automatic step(input int k);
		repeat (k) @(posedge pclk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask
	// master waits for pready; psel drops one cycle between transfers
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask
	task automatic results();
		$display("checked %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// hang guard: all scenarios together stay far below this ceiling
	always @(posedge pclk) cycle_cnt <= cycle_cnt + 1;
	initial begin
		wait (cycle_cnt >= 12000);
		error_cnt++;
		$display("[ERR] timeout expected %0d seen %0d", 12000, cycle_cnt);
		results();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{peer_on, peer_slow, alarm_in} = '0;
		src_live = 4'hf;
		error_cnt = 0;
		samples_checked = 0;
		presetn = 1'b0;
		rows[0] = {1'b0, SCS_CFG_OFF, 32'h0, 32'h4};
		rows[1] = {1'b0, SCS_SCHK_OFF, 32'h0, 32'h0103003c};
		rows[2] = {1'b0, SCS_TEST_OFF, 32'h0, 32'h0a};
		rows[3] = {1'b0, SCS_CLK_OFF, 32'h0, 32'h08};
		rows[4] = {1'b0, SCS_IRQ_OFF, 32'h0, 32'h0};
		rows[5] = {1'b0, 8'h20, 32'h0, 32'h0};
		rows[6] = {1'b1, SCS_CLK_OFF, 32'h05, 32'h08};
		rows[7] = {1'b0, SCS_IRQ_OFF, 32'h0, 32'h10};
		rows[8] = {1'b1, SCS_IRQ_OFF, 32'h10, 32'h0};
		rows[9] = {1'b1, SCS_CLK_OFF, 32'h0a, 32'h0a};
		rows[10] = {1'b1, SCS_SCHK_OFF, 32'h0102000a, 32'h0102000a};
		rows[11] = {1'b1, SCS_TEST_OFF, 32'h79, 32'h0a};
		rows[12] = {1'b1, SCS_TEST_OFF, 32'h01, 32'h01};
		rows[13] = {1'b1, SCS_CFG_OFF, 32'h1, 32'h1};
		step(8);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			if (rows[i].wr) apb(1'b1, rows[i].a, rows[i].d);
			rdchk("reg", rows[i].a, rows[i].e);
		end
		step(2);
		chk("ratio_byte_en", 1, ratio_byte_en);
		apb(1'b1, SCS_CFG_OFF, 32'h0);
		apb(1'b1, SCS_CLK_OFF, 32'h04);
		step(2);
		chk("ratio_byte_en", 0, ratio_byte_en);
		// misses counted but never declared with down-on-timeout off
		n = 0;
		while (schk_send !== 1'b1 && n < 1000) begin
			step(1);
			n++;
		end
		n = 0;
		do begin
			step(1);
			n++;
		end while (schk_send !== 1'b1 && n < 1000);
		chk("interval", 200, n);
		step(500);
		apb(1'b0, SCS_STAT_OFF, 32'h0);
		chk("inactive", 0, rd[10]);
		chk("miss seen", 1, rd[16:12] != 5'h00);
		apb(1'b1, SCS_MASK_OFF, 32'h1f);
		apb(1'b1, SCS_CFG_OFF, 32'h2);
		step(500);
		apb(1'b0, SCS_STAT_OFF, 32'h0);
		chk("inactive", 1, rd[10]);
		chk("irq", 1, irq);
		rdchk("irq st", SCS_IRQ_OFF, 32'h01);
		apb(1'b1, SCS_IRQ_OFF, 32'h01);
		peer_on <= 1'b1;
		peer_slow <= 1'b1;
		step(450);
		apb(1'b0, SCS_STAT_OFF, 32'h0);
		chk("inactive", 0, rd[10]);
		rdchk("irq st", SCS_IRQ_OFF, 32'h02);
		apb(1'b1, SCS_IRQ_OFF, 32'h1f);
		step(2);
		chk("irq", 0, irq);
		// relay: off while disabled, every source drives it once enabled
		alarm_in <= 12'h020;
		step(3);
		chk("relay", 0, relay_on);
		apb(1'b1, SCS_CFG_OFF, 32'h8);
		for (int i = 0; i < SCS_ALM_W; i++) begin
			alarm_in <= 12'h001 << i;
			step(3);
			chk("relay", 1, relay_on);
		end
		alarm_in <= 12'h060;
		step(3);
		alarm_in <= 12'h040;
		step(3);
		chk("relay", 1, relay_on);
		alarm_in <= 12'h000;
		step(3);
		chk("relay", 0, relay_on);
		alarm_in <= 12'h010;
		apb(1'b1, SCS_CMD_OFF, 32'h1);
		step(3);
		chk("relay", 0, relay_on);
		alarm_in <= 12'h090;
		step(3);
		chk("relay", 1, relay_on);
		alarm_in <= 12'h000;
		// test ends after one minute only with timeout on
		apb(1'b1, SCS_CFG_OFF, 32'h4);
		apb(1'b1, SCS_CMD_OFF, 32'h2);
		step(1100);
		chk("test", 1, test_active);
		step(300);
		chk("test", 0, test_active);
		rdchk("irq st", SCS_IRQ_OFF, 32'h04);
		apb(1'b1, SCS_CFG_OFF, 32'h0);
		apb(1'b1, SCS_CMD_OFF, 32'h2);
		step(1400);
		chk("test", 1, test_active);
		apb(1'b1, SCS_CMD_OFF, 32'h4);
		step(3);
		chk("test", 0, test_active);
		// fallback, second fallback, timed return
		chk("clk_sel", SCS_SRC_NET, clk_sel);
		src_live <= 4'he;
		step(60);
		chk("clk_sel", SCS_SRC_XC, clk_sel);
		src_live <= 4'hc;
		step(60);
		chk("clk_sel", SCS_SRC_INT, clk_sel);
		src_live <= 4'hd;
		step(150);
		chk("clk_sel", SCS_SRC_INT, clk_sel);
		step(150);
		chk("clk_sel", SCS_SRC_NET, clk_sel);
		apb(1'b0, SCS_IRQ_OFF, 32'h0);
		chk("clk fail", 1, rd[3]);
		// mid-run reset: outputs idle while held, defaults back after release
		presetn <= 1'b0;
		step(2);
		chk("rst outputs", 32'h0, {26'h0, relay_on, irq, test_active, schk_send, ratio_byte_en,
			pslverr});
		chk("rst clk_sel", SCS_SRC_NET, clk_sel);
		chk("rst prdata", 32'h0, prdata);
		chk("rst pready", 32'h1, pready);
		presetn <= 1'b1;
		rdchk("rst cfg", SCS_CFG_OFF, 32'h4);
		rdchk("rst schk", SCS_SCHK_OFF, 32'h0103003c);
		rdchk("rst irq st", SCS_IRQ_OFF, 32'h0);
		results();
	end
endmodule // scs_supervisor_bench

// File: verilog/scs_pkg.sv
// package for the service-check, clock and alarm supervisor
package scs_pkg;
	// apb register byte offsets
	localparam logic [7:0] SCS_CFG_OFF = 8'h00;
	localparam logic [7:0] SCS_SCHK_OFF = 8'h04;
	localparam logic [7:0] SCS_TEST_OFF = 8'h08;
	localparam logic [7:0] SCS_CLK_OFF = 8'h0c;
	localparam logic [7:0] SCS_STAT_OFF = 8'h10;
	localparam logic [7:0] SCS_IRQ_OFF = 8'h14;
	localparam logic [7:0] SCS_MASK_OFF = 8'h18;
	localparam logic [7:0] SCS_CMD_OFF = 8'h1c;
	// cfg register bits
	localparam int SCS_CFG_DR = 0;
	localparam int SCS_CFG_DOWN = 1;
	localparam int SCS_CFG_TTO = 2;
	localparam int SCS_CFG_RLY = 3;
	// cmd register bits (self-clearing)
	localparam int SCS_CMD_CUT = 0;
	localparam int SCS_CMD_TSTART = 1;
	localparam int SCS_CMD_TSTOP = 2;
	// schk fields: interval [11:0], miss thr [20:16], clear thr [28:24]
	localparam int SCS_IVL_LSB = 0;
	localparam int SCS_MISS_LSB = 16;
	localparam int SCS_CLR_LSB = 24;
	// reset values, limits and timer constants
	localparam logic [11:0] SCS_IVL_DEF = 12'h03c;
	localparam logic [11:0] SCS_IVL_MIN = 12'h00a;
	localparam logic [11:0] SCS_IVL_MAX = 12'he10;
	localparam logic [4:0] SCS_MISS_DEF = 5'h03;
	localparam logic [4:0] SCS_CLR_DEF = 5'h01;
	localparam logic [4:0] SCS_THR_MAX = 5'h14;
	localparam logic [6:0] SCS_TDUR_DEF = 7'h0a;
	localparam logic [6:0] SCS_TDUR_MAX = 7'h78;
	localparam logic [5:0] SCS_SEC_PER_MIN = 6'h3b;
	localparam logic [3:0] SCS_STABLE_SECS = 4'ha;
	// interrupt bits
	localparam int SCS_IRQ_DOWN = 0;
	localparam int SCS_IRQ_UP = 1;
	localparam int SCS_IRQ_TEND = 2;
	localparam int SCS_IRQ_CFAIL = 3;
	localparam int SCS_IRQ_REJ = 4;
	localparam int SCS_IRQ_W = 5;
	// alarm input bit count
	localparam int SCS_ALM_W = 12;
	// timing sources
	typedef enum logic [1:0] {
		SCS_SRC_NET = 2'h0,
		SCS_SRC_XC = 2'h1,
		SCS_SRC_INT = 2'h2,
		SCS_SRC_BKP = 2'h3
	} scs_src_t;
	typedef enum logic [1:0] {SCS_USE_PRI, SCS_USE_SEC, SCS_USE_INT} scs_csel_t;
	// clock rate and time constants
	localparam longint SCS_CLK_HZ = 250000000;
	localparam longint SCS_SEC_NS = 1000000000;
	localparam longint SCS_PERIOD_NS = SCS_SEC_NS / SCS_CLK_HZ;
	localparam longint SCS_TICK_CYC = SCS_SEC_NS / SCS_PERIOD_NS;
	localparam longint SCS_ACT_WIN_CYC = 1024;
endpackage

// File: verilog/scs_supervisor.sv
// service-check, timing source and alarm relay supervisor
`timescale 1ns/1ps
module scs_supervisor #(
	parameter longint TICK_CYC = scs_pkg::SCS_TICK_CYC,
	parameter longint ACT_WIN_CYC = scs_pkg::SCS_ACT_WIN_CYC
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// service-check link events
	output logic schk_send,
	input wire logic schk_rx,
	output logic ratio_byte_en,
	// test control
	output logic test_active,
	// timing source activity pins, indexed by scs_src_t
	input wire logic [3:0] src_activity,
	output scs_pkg::scs_src_t clk_sel,
	// alarm sources and relay
	input wire logic [scs_pkg::SCS_ALM_W-1:0] alarm_in,
	output logic relay_on,
	output logic irq
);
	import scs_pkg::*;

	localparam int TW = $clog2(TICK_CYC + 1);
	localparam int AW = $clog2(ACT_WIN_CYC + 1);

	typedef struct packed {
		logic [TW-1:0] tick_cnt;
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic [3:0] sync3;
		logic [3:0] seen;
		logic [3:0] ok;
		logic [AW-1:0] win_cnt;
		logic [3:0] cfg;
		logic [11:0] ivl;
		logic [4:0] miss_thr;
		logic [4:0] clr_thr;
		logic [6:0] tdur;
		logic [1:0] pri;
		logic [1:0] sec;
		logic [11:0] ivl_cnt;
		logic got_rx;
		logic [4:0] miss_cnt;
		logic [4:0] rx_cnt;
		logic inactive;
		logic tact;
		logic [5:0] tsec;
		logic [6:0] tmin;
		scs_csel_t csel;
		logic [3:0] stable_cnt;
		logic [SCS_ALM_W-1:0] alm_prev;
		logic cut;
		logic [SCS_IRQ_W-1:0] ists;
		logic [SCS_IRQ_W-1:0] imask;
		logic [31:0] rdata;
		logic send;
	} scs_state_t;

	scs_state_t s_r, s_nxt;
	logic [SCS_ALM_W-1:0] alm_all;
	logic wr, rd, tick;
	logic [SCS_IRQ_W-1:0] ev;

	////////////////////////////////////////////////////////////////////////////////
	// alarm vector: own conditions folded in with external ones
	always_comb begin
		alm_all = alarm_in;
		alm_all[0] = alarm_in[0] | (s_r.cfg[SCS_CFG_DOWN] & s_r.inactive);
		alm_all[1] = alarm_in[1] | (s_r.miss_cnt >= s_r.miss_thr);
		alm_all[2] = alarm_in[2] | ~s_r.ok[s_r.pri] | ~s_r.ok[s_r.sec];
	end

	assign wr = psel & penable & pwrite;
	assign rd = psel & ~penable & ~pwrite;
	assign tick = (s_r.tick_cnt == TW'(TICK_CYC - 1));

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic bad_cfg;
		logic [4:0] mth;
		logic [4:0] cth;
		logic [11:0] niv;
		logic [6:0] ndur;
		logic [1:0] npri;
		logic [1:0] nsec;
		bad_cfg = 1'b0;
		mth = pwdata[SCS_MISS_LSB +: 5];
		cth = pwdata[SCS_CLR_LSB +: 5];
		niv = pwdata[SCS_IVL_LSB +: 12];
		ndur = pwdata[6:0];
		npri = pwdata[1:0];
		nsec = pwdata[3:2];
		s_nxt = s_r;
		ev = '0;
		s_nxt.send = 1'b0;
		// one-second tick from the internal clock
		s_nxt.tick_cnt = tick ? '0 : s_r.tick_cnt + TW'(1);
		// activity: two-flop sync, then edge detect on flops 2 and 3
		s_nxt.sync1 = src_activity;
		s_nxt.sync2 = s_r.sync1;
		s_nxt.sync3 = s_r.sync2;
		s_nxt.seen = s_r.seen | (s_r.sync2 ^ s_r.sync3);
		if (s_r.win_cnt == AW'(ACT_WIN_CYC - 1)) begin
			s_nxt.win_cnt = '0;
			s_nxt.ok = s_r.seen; // no edge over window means failed
			s_nxt.ok[SCS_SRC_INT] = 1'b1;
			s_nxt.seen = '0;
		end else begin
			s_nxt.win_cnt = s_r.win_cnt + AW'(1);
		end
		// register writes
		if (wr) begin
			case (paddr)
				SCS_CFG_OFF: s_nxt.cfg = pwdata[3:0];
				SCS_SCHK_OFF: begin
					// out-of-range settings keep the old value
					if (niv >= SCS_IVL_MIN && niv <= SCS_IVL_MAX) s_nxt.ivl = niv;
					if (mth != '0 && mth <= SCS_THR_MAX) s_nxt.miss_thr = mth;
					if (cth != '0 && cth <= SCS_THR_MAX) s_nxt.clr_thr = cth;
				end
				SCS_TEST_OFF: if (ndur != '0 && ndur <= SCS_TDUR_MAX) s_nxt.tdur = ndur;
				SCS_CLK_OFF: begin
					bad_cfg = (npri == nsec) && (npri != SCS_SRC_INT);
					if (!bad_cfg) begin
						s_nxt.pri = npri;
						s_nxt.sec = nsec;
					end
				end
				SCS_IRQ_OFF: s_nxt.ists = s_r.ists & ~pwdata[SCS_IRQ_W-1:0];
				SCS_MASK_OFF: s_nxt.imask = pwdata[SCS_IRQ_W-1:0];
				SCS_CMD_OFF: begin
					if (pwdata[SCS_CMD_CUT]) s_nxt.cut = 1'b1;
					if (pwdata[SCS_CMD_TSTART]) begin
						s_nxt.tact = 1'b1;
						s_nxt.tsec = '0;
						s_nxt.tmin = '0;
					end
					if (pwdata[SCS_CMD_TSTOP]) s_nxt.tact = 1'b0;
				end
				default: ;
			endcase
		end
		if (bad_cfg) ev[SCS_IRQ_REJ] = 1'b1;
		// service-check scheduling and miss counting
		if (schk_rx) s_nxt.got_rx = 1'b1;
		if (tick) begin
			if (s_r.ivl_cnt + 12'h001 >= s_r.ivl) begin
				s_nxt.ivl_cnt = '0;
				s_nxt.send = 1'b1;
				s_nxt.got_rx = schk_rx;
				if (s_r.got_rx) begin
					s_nxt.miss_cnt = '0;
					if (s_r.inactive) begin
						s_nxt.rx_cnt = s_r.rx_cnt + 5'h01;
						if (s_r.rx_cnt + 5'h01 >= s_r.clr_thr) begin
							s_nxt.inactive = 1'b0;
							s_nxt.rx_cnt = '0;
							ev[SCS_IRQ_UP] = 1'b1;
						end
					end
				end else begin
					s_nxt.rx_cnt = '0;
					// counted always; only declares down when enabled
					if (s_r.miss_cnt != 5'h1f) s_nxt.miss_cnt = s_r.miss_cnt + 5'h01;
					// one bit wider so a saturated count still trips
					if ({1'b0, s_r.miss_cnt} + 6'h01 >= {1'b0, s_r.miss_thr} && s_r.cfg[SCS_CFG_DOWN]
						&& !s_r.inactive) begin
						s_nxt.inactive = 1'b1;
						ev[SCS_IRQ_DOWN] = 1'b1;
					end
				end
			end else begin
				s_nxt.ivl_cnt = s_r.ivl_cnt + 12'h001;
			end
		end
		if (!s_r.cfg[SCS_CFG_DOWN]) s_nxt.inactive = 1'b0;
		// test duration timer, minutes of one-second ticks
		if (s_r.tact && tick && s_r.cfg[SCS_CFG_TTO]) begin
			if (s_r.tsec == SCS_SEC_PER_MIN) begin
				s_nxt.tsec = '0;
				s_nxt.tmin = s_r.tmin + 7'h01;
				if (s_r.tmin + 7'h01 >= s_r.tdur) begin
					s_nxt.tact = 1'b0;
					ev[SCS_IRQ_TEND] = 1'b1;
				end
			end else begin
				s_nxt.tsec = s_r.tsec + 6'h01;
			end
		end
		// timing source selection
		case (s_r.csel)
			SCS_USE_PRI: if (!s_r.ok[s_r.pri]) begin
				s_nxt.csel = SCS_USE_SEC;
				ev[SCS_IRQ_CFAIL] = 1'b1;
			end
			SCS_USE_SEC, SCS_USE_INT: begin
				if (s_r.csel == SCS_USE_SEC && !s_r.ok[s_r.sec]) begin
					s_nxt.csel = SCS_USE_INT;
					ev[SCS_IRQ_CFAIL] = 1'b1;
				end
				// stability seconds restart whenever the primary drops
				if (!s_r.ok[s_r.pri]) s_nxt.stable_cnt = '0;
				else if (tick) begin
					s_nxt.stable_cnt = s_r.stable_cnt + 4'h1;
					// a partial first second does not count toward stability
					if (s_r.stable_cnt >= SCS_STABLE_SECS) begin
						s_nxt.csel = SCS_USE_PRI;
						s_nxt.stable_cnt = '0;
					end
				end
			end
			default: s_nxt.csel = SCS_USE_PRI;
		endcase
		// cut-off holds until a new alarm rises
		s_nxt.alm_prev = alm_all;
		if (|(alm_all & ~s_r.alm_prev)) s_nxt.cut = 1'b0;
		// sticky status: set wins over clear
		s_nxt.ists = s_nxt.ists | ev;
		// read data latched in the setup cycle
		if (rd) begin
			case (paddr)
				SCS_CFG_OFF: s_nxt.rdata = {28'h0, s_r.cfg};
				SCS_SCHK_OFF: s_nxt.rdata = {3'h0, s_r.clr_thr, 3'h0, s_r.miss_thr, 4'h0, s_r.ivl};
				SCS_TEST_OFF: s_nxt.rdata = {25'h0, s_r.tdur};
				SCS_CLK_OFF: s_nxt.rdata = {26'h0, s_r.csel, s_r.sec, s_r.pri};
				SCS_STAT_OFF: s_nxt.rdata = {11'h0, s_r.ok, s_r.miss_cnt, s_r.tact,
					s_r.inactive, 8'h0, s_r.cut, relay_on};
				SCS_IRQ_OFF: s_nxt.rdata = {{(32-SCS_IRQ_W){1'b0}}, s_r.ists};
				SCS_MASK_OFF: s_nxt.rdata = {{(32-SCS_IRQ_W){1'b0}}, s_r.imask};
				default: s_nxt.rdata = '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.cfg <= 4'(1 << SCS_CFG_TTO); // timeout on, others off
			s_r.ivl <= SCS_IVL_DEF;
			s_r.miss_thr <= SCS_MISS_DEF;
			s_r.clr_thr <= SCS_CLR_DEF;
			s_r.tdur <= SCS_TDUR_DEF;
			s_r.pri <= SCS_SRC_NET;
			s_r.sec <= SCS_SRC_INT;
			s_r.ok <= 4'hf;
			s_r.csel <= SCS_USE_PRI;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = s_r.rdata;
	assign schk_send = s_r.send;
	assign ratio_byte_en = s_r.cfg[SCS_CFG_DR];
	assign test_active = s_r.tact;
	assign relay_on = s_r.cfg[SCS_CFG_RLY] & (|s_r.alm_prev) & ~s_r.cut;
	assign irq = |(s_r.ists & s_r.imask);
	always_comb begin
		case (s_r.csel)
			SCS_USE_PRI: clk_sel = scs_src_t'(s_r.pri);
			SCS_USE_SEC: clk_sel = scs_src_t'(s_r.sec);
			default: clk_sel = SCS_SRC_INT;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////////
	a_relay_follows_alarm: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.cfg[SCS_CFG_RLY] && |s_r.alm_prev && !s_r.cut) |-> relay_on)
		else $error("relay off while alarm present");
	a_relay_disabled_off: assert property (@(posedge pclk) disable iff (!presetn)
		!s_r.cfg[SCS_CFG_RLY] |-> !relay_on)
		else $error("relay on while option disabled");
	a_cut_rearm: assert property (@(posedge pclk) disable iff (!presetn)
		(|(alm_all & ~s_r.alm_prev) && s_r.cfg[SCS_CFG_RLY]) |=> relay_on)
		else $error("new alarm did not re-energise relay");
	a_no_down_disabled: assert property (@(posedge pclk) disable iff (!presetn)
		!s_r.cfg[SCS_CFG_DOWN] |=> !s_r.inactive)
		else $error("circuit down with option disabled");
	a_down_needs_miss: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_r.inactive) |-> s_r.miss_cnt >= s_r.miss_thr)
		else $error("inactive before miss threshold");
	a_down_irq: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(s_r.inactive) |-> s_r.ists[SCS_IRQ_DOWN])
		else $error("no alarm event on circuit down");
	a_clk_same_reject: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.pri == s_r.sec) |-> (s_r.pri == SCS_SRC_INT))
		else $error("equal non-internal timing sources");
	sequence s_pri_fail;
		s_r.csel == SCS_USE_PRI && !s_r.ok[s_r.pri];
	endsequence
	a_fallback_sec: assert property (@(posedge pclk) disable iff (!presetn)
		s_pri_fail |=> s_r.csel == SCS_USE_SEC)
		else $error("no fallback to secondary");
	a_sec_to_int: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.csel == SCS_USE_SEC && !s_r.ok[s_r.sec] && !s_r.ok[s_r.pri]) |=> clk_sel == SCS_SRC_INT)
		else $error("no switch to internal");
	a_revert_stable: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.csel != SCS_USE_PRI ##1 s_r.csel == SCS_USE_PRI) |->
		$past(s_r.stable_cnt) == SCS_STABLE_SECS)
		else $error("reverted before stable time");
	a_test_no_timeout: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.tact && !s_r.cfg[SCS_CFG_TTO] && !(wr && paddr == SCS_CMD_OFF)) |=> s_r.tact)
		else $error("test ended without timeout enabled");
	a_ratio_byte: assert property (@(posedge pclk) disable iff (!presetn)
		ratio_byte_en == s_r.cfg[SCS_CFG_DR])
		else $error("ratio byte enable mismatch");
	a_clk_reject_irq: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == SCS_CLK_OFF && pwdata[1:0] == pwdata[3:2] && pwdata[1:0] != SCS_SRC_INT)
		|=> s_r.ists[SCS_IRQ_REJ])
		else $error("rejected timing setting not flagged");
	a_send_single: assert property (@(posedge pclk) disable iff (!presetn)
		schk_send |=> !schk_send)
		else $error("service-check send longer than one cycle");
endmodule // scs_supervisor
